// *** bim_pkg.sv ***
package bim_pkg;

    localparam int unsigned   BIM_ADDR_W        = 7;
    localparam int unsigned   BIM_DATA_W        = 24;
    localparam int unsigned   BIM_FLAG_LO       = 8;
    localparam int unsigned   BIM_FLAG_HI       = 23;
    localparam int unsigned   BIM_FLAG_W        = BIM_FLAG_HI - BIM_FLAG_LO + 1;

    localparam logic [6:0]    BIM_ADDR_MASK_PRI = 7'h02;
    localparam logic [6:0]    BIM_ADDR_MASK_SEC = 7'h03;
    localparam logic [6:0]    BIM_ADDR_MGMT     = 7'h04;

    localparam logic [23:0]   BIM_MASK_WR_BITS  = 24'hff8f03;
    localparam logic [23:0]   BIM_MASK_RST      = 24'h000003;
    localparam logic [23:0]   BIM_MGMT_WR_BITS  = 24'hff0077;
    localparam logic [23:0]   BIM_MGMT_RST      = 24'h7b0004;

    // Status flag positions
    localparam int unsigned   BIM_BIT_ECG_FIFO  = 23;
    localparam int unsigned   BIM_BIT_FASTREC   = 21;
    localparam int unsigned   BIM_BIT_IMP_FIFO  = 19;
    localparam int unsigned   BIM_BIT_BEAT      = 10;
    localparam int unsigned   BIM_BIT_SAMPLE_SYNC_PULSE      = 9;

    // Management register fields; BIM_DRV_HI/BIM_DRV_LO are the driver type field of the mask registers
    localparam int unsigned   BIM_ECG_WM_HI     = 23;
    localparam int unsigned   BIM_ECG_WM_LO     = 19;
    localparam int unsigned   BIM_IMP_WM_HI     = 18;
    localparam int unsigned   BIM_IMP_WM_LO     = 16;
    localparam int unsigned   BIM_FAST_CLR_BIT  = 6;
    localparam int unsigned   BIM_BEAT_CLR_HI   = 5;
    localparam int unsigned   BIM_BEAT_CLR_LO   = 4;
    localparam int unsigned   BIM_SAMPLE_SYNC_PULSE_CLR_BIT  = 2;
    localparam int unsigned   BIM_SAMPLE_SYNC_PULSE_RATE_HI  = 1;
    localparam int unsigned   BIM_SAMPLE_SYNC_PULSE_RATE_LO  = 0;
    localparam int unsigned   BIM_DRV_HI        = 1;
    localparam int unsigned   BIM_DRV_LO        = 0;

    localparam logic [1:0]    BIM_DRV_HIZ       = 2'h0;
    localparam logic [1:0]    BIM_DRV_PUSHPULL  = 2'h1;
    localparam logic [1:0]    BIM_DRV_OD        = 2'h2;
    localparam logic [1:0]    BIM_DRV_OD_PULLUP = 2'h3;

    localparam logic [1:0]    BIM_BEAT_CLR_STAT = 2'h0;
    localparam logic [1:0]    BIM_BEAT_CLR_INTV = 2'h1;
    localparam logic [1:0]    BIM_BEAT_CLR_SELF = 2'h2;

    localparam logic [3:0]    BIM_SAMPLE_SYNC_PULSE_DIV1     = 4'h0;
    localparam logic [3:0]    BIM_SAMPLE_SYNC_PULSE_DIV2     = 4'h1;
    localparam logic [3:0]    BIM_SAMPLE_SYNC_PULSE_DIV4     = 4'h3;
    localparam logic [3:0]    BIM_SAMPLE_SYNC_PULSE_DIV16    = 4'hf;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [BIM_ADDR_W-1:0] addr;
        logic [BIM_DATA_W-1:0] wdata;
    } bim_reg_req_s;

    typedef struct packed {
        logic drive;
        logic oe;
        logic pullup_en;
    } bim_pin_s;

endpackage : bim_pkg

// *** bim_flag_latch.sv ***
`timescale 1ns/1ps
module bim_flag_latch
    import bim_pkg::*;
#(
    parameter int unsigned W = 16
) (
    input  wire logic         core_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    output logic      [W-1:0] flag_o
);

    typedef struct packed {
        logic [W-1:0] flag;
    } bim_latch_s;

    bim_latch_s st_reg;
    bim_latch_s st_next;

    // Set wins over a clear arriving in the same cycle
    always_comb begin
        st_next = st_reg;
        for (int i = 0; i < W; i++) begin
            st_next.flag[i] = set_i[i] | (st_reg.flag[i] & ~clr_i[i]);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag_o = st_reg.flag;

endmodule : bim_flag_latch

// *** bim_pin_driver.sv ***
`timescale 1ns/1ps
module bim_pin_driver
    import bim_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       irq_active_i,
    input  wire logic [1:0] drv_type_i,
    output bim_pin_s        pin_o
);

    typedef struct packed {
        bim_pin_s pin;
    } bim_drv_s;

    bim_drv_s st_reg;
    bim_drv_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.pin.pullup_en = (drv_type_i == BIM_DRV_OD_PULLUP);
        unique case (drv_type_i)
            BIM_DRV_HIZ: begin
                st_next.pin.drive = 1'b1;
                st_next.pin.oe    = 1'b0;
            end
            BIM_DRV_PUSHPULL: begin
                st_next.pin.drive = ~irq_active_i;
                st_next.pin.oe    = 1'b1;
            end
            default: begin
                // Open drain: only ever pulls low so the line can be shared
                st_next.pin.drive = 1'b0;
                st_next.pin.oe    = irq_active_i;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_reg <= '{pin: '{drive: 1'b0, oe: 1'b0, pullup_en: 1'b1}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pin_o = st_reg.pin;

endmodule : bim_pin_driver

// *** bim_irq_manager.sv ***
`timescale 1ns/1ps
module bim_irq_manager
    import bim_pkg::*;
#(
    parameter int unsigned ECG_CNT_W = 6,
    parameter int unsigned IMP_CNT_W = 4
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   sys_rst_i,
    input  wire bim_reg_req_s           reg_req_i,
    output logic [BIM_DATA_W-1:0]       reg_rdata_o,
    input  wire logic                   status_read_done_i,
    input  wire logic                   beat_interval_read_i,
    input  wire logic [BIM_FLAG_W-1:0]  cond_i,
    input  wire logic [ECG_CNT_W-1:0]   ecg_fifo_count_i,
    input  wire logic [IMP_CNT_W-1:0]   imp_fifo_count_i,
    input  wire logic                   fast_mode_i,
    input  wire logic                   beat_event_i,
    input  wire logic                   sample_instant_i,
    input  wire logic                   ecg_rate_tick_i,
    input  wire logic                   quarter_rate_tick_i,
    output logic [BIM_DATA_W-1:0]       status_o,
    output logic                        irq_out_primary_n_o,
    output logic                        irq_out_primary_oe_o,
    output logic                        irq_out_primary_pullup_o,
    output logic                        irq_out_secondary_n_o,
    output logic                        irq_out_secondary_oe_o,
    output logic                        irq_out_secondary_pullup_o
);

    typedef struct packed {
        logic [BIM_DATA_W-1:0] mask_pri;
        logic [BIM_DATA_W-1:0] mask_sec;
        logic [BIM_DATA_W-1:0] mgmt;
        logic [BIM_DATA_W-1:0] rdata;
        logic                  fast_armed;
        logic [3:0]            sample_sync_pulse_cnt;
        logic                  beat_tick_seen;
    } bim_mgr_s;

    bim_mgr_s                 st_reg;
    bim_mgr_s                 st_next;
    logic [BIM_FLAG_W-1:0]    flags;
    logic [BIM_FLAG_W-1:0]    flag_set;
    logic [BIM_FLAG_W-1:0]    flag_clr;
    logic                     irq_pri_act;
    logic                     irq_sec_act;
    logic [4:0]               ecg_wm;
    logic [2:0]               imp_wm;
    logic                     fast_clr_mode;
    logic [1:0]               beat_clr_mode;
    logic                     sample_sync_pulse_clr_mode;
    logic [1:0]               sample_sync_pulse_rate;
    logic [3:0]               sample_sync_pulse_div_mask;
    logic                     sample_sync_pulse_fire;
    logic                     ecg_wm_hit;
    logic                     imp_wm_hit;
    bim_pin_s                 pin_pri;
    bim_pin_s                 pin_sec;

    localparam int unsigned   F_ECG  = BIM_BIT_ECG_FIFO - BIM_FLAG_LO;
    localparam int unsigned   F_FAST = BIM_BIT_FASTREC - BIM_FLAG_LO;
    localparam int unsigned   F_IMP  = BIM_BIT_IMP_FIFO - BIM_FLAG_LO;
    localparam int unsigned   F_BEAT = BIM_BIT_BEAT - BIM_FLAG_LO;
    localparam int unsigned   F_SAMPLE_SYNC_PULSE = BIM_BIT_SAMPLE_SYNC_PULSE - BIM_FLAG_LO;

    assign ecg_wm        = st_reg.mgmt[BIM_ECG_WM_HI:BIM_ECG_WM_LO];
    assign imp_wm        = st_reg.mgmt[BIM_IMP_WM_HI:BIM_IMP_WM_LO];
    assign fast_clr_mode = st_reg.mgmt[BIM_FAST_CLR_BIT];
    assign beat_clr_mode = st_reg.mgmt[BIM_BEAT_CLR_HI:BIM_BEAT_CLR_LO];
    assign sample_sync_pulse_clr_mode = st_reg.mgmt[BIM_SAMPLE_SYNC_PULSE_CLR_BIT];
    assign sample_sync_pulse_rate     = st_reg.mgmt[BIM_SAMPLE_SYNC_PULSE_RATE_HI:BIM_SAMPLE_SYNC_PULSE_RATE_LO];

    // Compare in a wider domain so field value 31 still reaches 32 records
    assign ecg_wm_hit = ({1'b0, ecg_fifo_count_i} >= (ECG_CNT_W+1)'(ecg_wm) + 1'b1);
    assign imp_wm_hit = ({1'b0, imp_fifo_count_i} >= (IMP_CNT_W+1)'(imp_wm) + 1'b1);

    always_comb begin
        unique case (sample_sync_pulse_rate)
            2'h0:    sample_sync_pulse_div_mask = BIM_SAMPLE_SYNC_PULSE_DIV1;
            2'h1:    sample_sync_pulse_div_mask = BIM_SAMPLE_SYNC_PULSE_DIV2;
            2'h2:    sample_sync_pulse_div_mask = BIM_SAMPLE_SYNC_PULSE_DIV4;
            default: sample_sync_pulse_div_mask = BIM_SAMPLE_SYNC_PULSE_DIV16;
        endcase
    end

    assign sample_sync_pulse_fire = sample_instant_i & ((st_reg.sample_sync_pulse_cnt & sample_sync_pulse_div_mask) == 4'h0);

    always_comb begin
        flag_set = cond_i;
        flag_clr = {BIM_FLAG_W{status_read_done_i}};
        flag_set[F_ECG] = ecg_wm_hit;
        flag_set[F_IMP] = imp_wm_hit;
        // Mode 1 raises only on entry, so a read clears it while fast mode runs on
        flag_set[F_FAST] = fast_clr_mode ? (fast_mode_i & st_reg.fast_armed)
                                         : fast_mode_i;
        flag_set[F_BEAT] = beat_event_i;
        unique case (beat_clr_mode)
            BIM_BEAT_CLR_STAT: flag_clr[F_BEAT] = status_read_done_i;
            BIM_BEAT_CLR_INTV: flag_clr[F_BEAT] = beat_interval_read_i;
            BIM_BEAT_CLR_SELF: flag_clr[F_BEAT] = ecg_rate_tick_i & st_reg.beat_tick_seen;
            default:           flag_clr[F_BEAT] = 1'b0;
        endcase
        flag_set[F_SAMPLE_SYNC_PULSE] = sample_sync_pulse_fire;
        flag_clr[F_SAMPLE_SYNC_PULSE] = sample_sync_pulse_clr_mode ? quarter_rate_tick_i : status_read_done_i;
    end

    bim_flag_latch #(
        .W          (BIM_FLAG_W)
    ) u_flags (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .set_i      (flag_set),
        .clr_i      (flag_clr),
        .flag_o     (flags)
    );

    assign irq_pri_act = |(flags & st_reg.mask_pri[BIM_FLAG_HI:BIM_FLAG_LO]);
    assign irq_sec_act = |(flags & st_reg.mask_sec[BIM_FLAG_HI:BIM_FLAG_LO]);

    always_comb begin
        st_next = st_reg;
        // Armed again only once fast mode has been left
        st_next.fast_armed = ~fast_mode_i;
        if (sample_instant_i) begin
            st_next.sample_sync_pulse_cnt = st_reg.sample_sync_pulse_cnt + 4'h1;
        end
        if (beat_event_i) begin
            st_next.beat_tick_seen = 1'b0;
        end else if (ecg_rate_tick_i) begin
            st_next.beat_tick_seen = 1'b1;
        end
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                BIM_ADDR_MASK_PRI: st_next.mask_pri = reg_req_i.wdata & BIM_MASK_WR_BITS;
                BIM_ADDR_MASK_SEC: st_next.mask_sec = reg_req_i.wdata & BIM_MASK_WR_BITS;
                BIM_ADDR_MGMT:     st_next.mgmt     = reg_req_i.wdata & BIM_MGMT_WR_BITS;
                default: ;
            endcase
        end
        if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                BIM_ADDR_MASK_PRI: st_next.rdata = st_reg.mask_pri;
                BIM_ADDR_MASK_SEC: st_next.rdata = st_reg.mask_sec;
                BIM_ADDR_MGMT:     st_next.rdata = st_reg.mgmt;
                default:           st_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_reg.mask_pri       <= BIM_MASK_RST;
            st_reg.mask_sec       <= BIM_MASK_RST;
            st_reg.mgmt           <= BIM_MGMT_RST;
            st_reg.rdata          <= '0;
            st_reg.fast_armed     <= 1'b1;
            st_reg.sample_sync_pulse_cnt       <= 4'h0;
            st_reg.beat_tick_seen <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    bim_pin_driver u_pin_pri (
        .core_clk_i   (core_clk_i),
        .sys_rst_i    (sys_rst_i),
        .irq_active_i (irq_pri_act),
        .drv_type_i   (st_reg.mask_pri[BIM_DRV_HI:BIM_DRV_LO]),
        .pin_o        (pin_pri)
    );

    bim_pin_driver u_pin_sec (
        .core_clk_i   (core_clk_i),
        .sys_rst_i    (sys_rst_i),
        .irq_active_i (irq_sec_act),
        .drv_type_i   (st_reg.mask_sec[BIM_DRV_HI:BIM_DRV_LO]),
        .pin_o        (pin_sec)
    );

    assign reg_rdata_o                = st_reg.rdata;
    assign status_o                   = {flags, 8'h00};
    assign irq_out_primary_n_o        = pin_pri.drive;
    assign irq_out_primary_oe_o       = pin_pri.oe;
    assign irq_out_primary_pullup_o   = pin_pri.pullup_en;
    assign irq_out_secondary_n_o      = pin_sec.drive;
    assign irq_out_secondary_oe_o     = pin_sec.oe;
    assign irq_out_secondary_pullup_o = pin_sec.pullup_en;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    logic line_pri_low;
    assign line_pri_low = irq_out_primary_oe_o & ~irq_out_primary_n_o;

    a_reset_masks: assert property ($past(sys_rst_i) |-> st_reg.mask_pri == BIM_MASK_RST
        && st_reg.mask_sec == BIM_MASK_RST) else $error("masks not at reset value");
    a_drv_type_reset: assert property ($past(sys_rst_i) |->
        st_reg.mask_pri[BIM_DRV_HI:BIM_DRV_LO] == BIM_DRV_OD_PULLUP)
        else $error("driver type not open drain with pull-up after reset");
    a_irq_or_term: assert property (
        st_reg.mask_pri[BIM_DRV_HI:BIM_DRV_LO] != BIM_DRV_HIZ && $stable(st_reg.mask_pri)
        |=> line_pri_low == $past(|(flags & st_reg.mask_pri[BIM_FLAG_HI:BIM_FLAG_LO])))
        else $error("primary line does not follow enabled flags");
    a_od_never_high: assert property (
        st_reg.mask_sec[BIM_DRV_HI] && $stable(st_reg.mask_sec) |=> !irq_out_secondary_n_o)
        else $error("open drain output drives high");
    a_hiz_off: assert property (st_reg.mask_pri[BIM_DRV_HI:BIM_DRV_LO] == BIM_DRV_HIZ
        && $stable(st_reg.mask_pri) |=> !irq_out_primary_oe_o)
        else $error("disabled output still enabled");
    a_ecg_wm_set: assert property (ecg_wm_hit |=> status_o[BIM_BIT_ECG_FIFO])
        else $error("ECG watermark flag not raised");
    a_imp_wm_set: assert property (imp_wm_hit |=> status_o[BIM_BIT_IMP_FIFO])
        else $error("impedance watermark flag not raised");
    a_fast_held: assert property (!fast_clr_mode && fast_mode_i |=> status_o[BIM_BIT_FASTREC])
        else $error("fast flag dropped while fast mode engaged");
    a_fast_readclr: assert property (fast_clr_mode && !st_reg.fast_armed
        && status_read_done_i |=> !status_o[BIM_BIT_FASTREC])
        else $error("fast flag not cleared by read in mode 1");
    a_beat_intv_clr: assert property (beat_clr_mode == BIM_BEAT_CLR_INTV
        && beat_interval_read_i && !beat_event_i |=> !status_o[BIM_BIT_BEAT])
        else $error("beat flag not cleared by interval read");
    a_read_clears: assert property (status_read_done_i && cond_i == '0 && !fast_mode_i
        && !ecg_wm_hit && !imp_wm_hit |=> status_o[BIM_FLAG_HI:BIM_FLAG_LO + 12] == 4'h0)
        else $error("status read did not clear latched flags");
    a_unused_zero: assert property (reg_req_i.rd && reg_req_i.addr == BIM_ADDR_MGMT
        |=> (reg_rdata_o & ~BIM_MGMT_WR_BITS) == 24'h000000)
        else $error("unused management bits read nonzero");

    // Pin checks look one cycle on, past the driver flop
    a_sec_or_term: assert property (
        st_reg.mask_sec[BIM_DRV_HI:BIM_DRV_LO] != BIM_DRV_HIZ
        |=> (irq_out_secondary_oe_o & ~irq_out_secondary_n_o) == $past(irq_sec_act))
        else $error("secondary line does not follow enabled flags");
    a_sec_drv_reset: assert property ($past(sys_rst_i)
        |-> st_reg.mask_sec[BIM_DRV_HI:BIM_DRV_LO] == BIM_DRV_OD_PULLUP)
        else $error("secondary driver type wrong after reset");
    a_pullup_sel: assert property (
        st_reg.mask_pri[BIM_DRV_HI:BIM_DRV_LO] == BIM_DRV_OD_PULLUP
        |=> irq_out_primary_pullup_o) else $error("pull-up not enabled");
    a_pp_drives: assert property (
        st_reg.mask_pri[BIM_DRV_HI:BIM_DRV_LO] == BIM_DRV_PUSHPULL
        |=> irq_out_primary_oe_o) else $error("push-pull output not driven");
    a_od_pri_low: assert property (
        st_reg.mask_pri[BIM_DRV_HI]
        |=> !irq_out_primary_n_o) else $error("primary open drain drives high");
    a_hiz_sec_off: assert property (
        st_reg.mask_sec[BIM_DRV_HI:BIM_DRV_LO] == BIM_DRV_HIZ
        |=> !irq_out_secondary_oe_o) else $error("disabled secondary still enabled");
    a_ecg_wm_low: assert property (
        ecg_fifo_count_i <= ECG_CNT_W'(ecg_wm) && !status_o[BIM_BIT_ECG_FIFO]
        |=> !status_o[BIM_BIT_ECG_FIFO]) else $error("ECG flag raised early");
    a_imp_wm_low: assert property (
        imp_fifo_count_i <= IMP_CNT_W'(imp_wm) && !status_o[BIM_BIT_IMP_FIFO]
        |=> !status_o[BIM_BIT_IMP_FIFO]) else $error("impedance flag raised early");
    a_fast_latched: assert property (
        !fast_clr_mode && status_o[BIM_BIT_FASTREC] && !status_read_done_i
        |=> status_o[BIM_BIT_FASTREC]) else $error("fast flag lost before read");
    a_fast_no_rearm: assert property (
        fast_clr_mode && fast_mode_i && $past(fast_mode_i) && !$past(sys_rst_i)
        && !status_o[BIM_BIT_FASTREC]
        |=> !status_o[BIM_BIT_FASTREC]) else $error("fast flag raised again");
    a_beat_stat_clr: assert property (
        beat_clr_mode == BIM_BEAT_CLR_STAT && status_read_done_i && !beat_event_i
        |=> !status_o[BIM_BIT_BEAT]) else $error("beat flag not cleared by read");
    a_beat_self_hold: assert property (
        beat_clr_mode == BIM_BEAT_CLR_SELF && !ecg_rate_tick_i && status_o[BIM_BIT_BEAT]
        |=> status_o[BIM_BIT_BEAT]) else $error("beat flag cleared without tick");
    a_sample_sync_pulse_self_clr: assert property (
        sample_sync_pulse_clr_mode && quarter_rate_tick_i && !sample_instant_i
        |=> !status_o[BIM_BIT_SAMPLE_SYNC_PULSE]) else $error("sample pulse not self-cleared");
    a_sample_sync_pulse_read_clr: assert property (
        !sample_sync_pulse_clr_mode && status_read_done_i && !sample_instant_i
        |=> !status_o[BIM_BIT_SAMPLE_SYNC_PULSE]) else $error("sample pulse not cleared by read");
    a_sample_sync_pulse_no_fire: assert property (
        !sample_instant_i && !status_o[BIM_BIT_SAMPLE_SYNC_PULSE]
        |=> !status_o[BIM_BIT_SAMPLE_SYNC_PULSE]) else $error("sample pulse without instant");
    a_mask_unused: assert property (
        reg_req_i.rd && reg_req_i.addr == BIM_ADDR_MASK_PRI
        |=> (reg_rdata_o & ~BIM_MASK_WR_BITS) == 24'h000000)
        else $error("unused mask bits read nonzero");

    c_pri_assert:  cover property (line_pri_low);
    c_beat_self:   cover property (beat_clr_mode == BIM_BEAT_CLR_SELF && flag_clr[F_BEAT]);
    c_sample_sync_pulse_div16:  cover property (sample_sync_pulse_rate == 2'h3 && sample_sync_pulse_fire);
    c_fast_rearm:  cover property (fast_clr_mode && flag_set[F_FAST]);
    c_sec_assert:  cover property (irq_out_secondary_oe_o && !irq_out_secondary_n_o);

endmodule : bim_irq_manager

// *** bim_host_model.sv ***
`timescale 1ns/1ps
module bim_host_model
    import bim_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic pin_n_i,
    input  wire logic pin_oe_i,
    input  wire logic pin_pullup_i,
    output logic      line_o,
    output logic      service_o
);
    logic line_last_reg = 1'b0;

    // A floating line with no pull-up keeps moving, so a stale level never passes
    assign line_o    = pin_oe_i ? pin_n_i : (pin_pullup_i ? 1'b1 : ~line_last_reg);
    // Low level asks the host for service
    assign service_o = ~line_o;

    always_ff @(posedge core_clk_i) begin
        line_last_reg <= line_o;
    end
endmodule : bim_host_model

// *** tb_bim_irq_manager.sv ***
`timescale 1ns/1ps
module tb_bim_irq_manager
    import bim_pkg::*;
;
    localparam int P_SRD = 0;
    localparam int P_BIRD = 1;
    localparam int P_BEAT = 2;
    localparam int P_SAMPLE_SYNC_PULSE = 3;
    localparam int P_ETK = 4;
    localparam int P_QTK = 5;

    logic         core_clk;
    logic         sys_rst;
    bim_reg_req_s req;
    logic [23:0]  rdata;
    logic [23:0]  status;
    logic [15:0]  cond;
    logic [5:0]   ecnt;
    logic [3:0]   icnt;
    logic         srd, bird, beat, sample_sync_pulse, etick, qtick, fast;
    logic         p_n, p_oe, p_pu, s_n, s_oe, s_pu, line_p, line_s;
    int           error_cnt = 0;
    int           tests_run = 0;
    int           cnt;
    // Index {active, type}: {oe, driven level high, pull-up}
    logic [2:0]   pin_exp [8] = '{3'h0, 3'h6, 3'h0, 3'h1, 3'h0, 3'h4, 3'h4, 3'h5};
    logic [23:0]  wm_cfg [2] = '{24'h100004, 24'hff0004};
    logic [5:0]   wm_elo [2] = '{6'h02, 6'h1f};
    logic [3:0]   wm_ilo [2] = '{4'h0, 4'h7};

    bim_irq_manager dut (
        .core_clk_i(core_clk), .sys_rst_i(sys_rst), .reg_req_i(req), .reg_rdata_o(rdata),
        .status_read_done_i(srd), .beat_interval_read_i(bird), .cond_i(cond),
        .ecg_fifo_count_i(ecnt), .imp_fifo_count_i(icnt), .fast_mode_i(fast),
        .beat_event_i(beat), .sample_instant_i(sample_sync_pulse), .ecg_rate_tick_i(etick),
        .quarter_rate_tick_i(qtick), .status_o(status),
        .irq_out_primary_n_o(p_n), .irq_out_primary_oe_o(p_oe),
        .irq_out_primary_pullup_o(p_pu), .irq_out_secondary_n_o(s_n),
        .irq_out_secondary_oe_o(s_oe), .irq_out_secondary_pullup_o(s_pu));

    bim_host_model host_pri (.core_clk_i(core_clk), .pin_n_i(p_n), .pin_oe_i(p_oe),
        .pin_pullup_i(p_pu), .line_o(line_p), .service_o());
    bim_host_model host_sec (.core_clk_i(core_clk), .pin_n_i(s_n), .pin_oe_i(s_oe),
        .pin_pullup_i(s_pu), .line_o(line_s), .service_o());

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask : step

    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: pin %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic reg_wr(input logic [6:0] a, input logic [23:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        step(1);
        req.wr = 1'b0;
        step(1);
    endtask : reg_wr

    task automatic reg_rd(input logic [6:0] a, input logic [23:0] exp);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h000000};
        step(1);
        req.rd = 1'b0;
        chk_val(rdata, exp);
        step(1);
    endtask : reg_rd

    task automatic pulse(input int k);
        case (k)
            P_SRD:  srd = 1'b1;
            P_BIRD: bird = 1'b1;
            P_BEAT: beat = 1'b1;
            P_SAMPLE_SYNC_PULSE: sample_sync_pulse = 1'b1;
            P_ETK:  etick = 1'b1;
            default: qtick = 1'b1;
        endcase
        step(1);
        {srd, bird, beat, sample_sync_pulse, etick, qtick} = 6'h00;
        step(1);
    endtask : pulse

    task automatic final_report;
        $display("mismatches %0d, comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    initial begin
        #2ms;
        error_cnt++;
        final_report();
    end

    initial begin
        sys_rst = 1'b1;
        req = '0;
        cond = 16'h0000;
        ecnt = 6'h00;
        icnt = 4'h0;
        {srd, bird, beat, sample_sync_pulse, etick, qtick, fast} = 7'h00;
        step(8);
        sys_rst = 1'b0;
        reg_rd(BIM_ADDR_MASK_PRI, BIM_MASK_RST);
        reg_rd(BIM_ADDR_MASK_SEC, BIM_MASK_RST);
        reg_rd(BIM_ADDR_MGMT, BIM_MGMT_RST);
        chk_pin({p_oe, p_pu, line_p}, 3'h3);
        chk_pin({s_oe, s_pu, line_s}, 3'h3);
        reg_wr(7'h05, 24'hffffff);
        reg_rd(7'h05, 24'h000000);
        reg_wr(BIM_ADDR_MASK_PRI, 24'hffffff);
        reg_rd(BIM_ADDR_MASK_PRI, BIM_MASK_WR_BITS);
        reg_wr(BIM_ADDR_MGMT, 24'hffffdf);
        reg_rd(BIM_ADDR_MGMT, BIM_MGMT_WR_BITS & 24'hffffdf);
        reg_wr(BIM_ADDR_MGMT, BIM_MGMT_RST);
        // Enable bit 17 on the open-drain primary, bit 8 on the push-pull secondary
        reg_wr(BIM_ADDR_MASK_PRI, 24'h020002);
        reg_wr(BIM_ADDR_MASK_SEC, 24'h000101);
        cond[0] = 1'b1;
        step(1);
        chk_val(status, 24'h000100);
        step(1);
        chk_pin({p_oe, 1'b0, line_s}, 3'h0);
        cond[9] = 1'b1;
        step(2);
        chk_pin({p_oe, p_n, line_p}, 3'h4);
        reg_wr(BIM_ADDR_MASK_PRI, 24'h000002);
        step(1);
        chk_pin({p_oe, 2'h0}, 3'h0);
        for (int a = 0; a < 2; a++) begin
            for (int t = 0; t < 4; t++) begin
                reg_wr(BIM_ADDR_MASK_PRI, {15'h0000, a[0], 6'h00, t[1:0]});
                step(1);
                chk_pin({p_oe, p_oe & p_n, p_pu}, pin_exp[a * 4 + t]);
            end
        end
        cond = 16'h0000;
        step(1);
        chk_val(status, 24'h020100);
        pulse(P_SRD);
        chk_val(status, 24'h000000);
        for (int i = 0; i < 2; i++) begin
            reg_wr(BIM_ADDR_MGMT, wm_cfg[i]);
            ecnt = wm_elo[i];
            icnt = wm_ilo[i];
            step(1);
            chk_val(status, 24'h000000);
            ecnt = wm_elo[i] + 6'h01;
            icnt = wm_ilo[i] + 4'h1;
            step(1);
            chk_val(status, 24'h880000);
            ecnt = 6'h00;
            icnt = 4'h0;
            pulse(P_SRD);
        end
        reg_wr(BIM_ADDR_MGMT, BIM_MGMT_RST);
        fast = 1'b1;
        step(1);
        pulse(P_SRD);
        chk_val(status, 24'h200000);
        fast = 1'b0;
        step(1);
        chk_val(status, 24'h200000);
        pulse(P_SRD);
        chk_val(status, 24'h000000);
        reg_wr(BIM_ADDR_MGMT, 24'h7b0044);
        fast = 1'b1;
        step(1);
        chk_val(status, 24'h200000);
        pulse(P_SRD);
        step(2);
        chk_val(status, 24'h000000);
        fast = 1'b0;
        step(1);
        fast = 1'b1;
        step(1);
        chk_val(status, 24'h200000);
        fast = 1'b0;
        pulse(P_SRD);
        // Only the codes 00, 01 and 10 are ever written to the beat clear field
        reg_wr(BIM_ADDR_MGMT, BIM_MGMT_RST);
        pulse(P_BEAT);
        pulse(P_BIRD);
        chk_val(status, 24'h000400);
        pulse(P_SRD);
        chk_val(status, 24'h000000);
        reg_wr(BIM_ADDR_MGMT, 24'h7b0014);
        pulse(P_BEAT);
        chk_val(status, 24'h000400);
        pulse(P_BIRD);
        chk_val(status, 24'h000000);
        reg_wr(BIM_ADDR_MGMT, 24'h7b0024);
        pulse(P_BEAT);
        pulse(P_ETK);
        chk_val(status, 24'h000400);
        pulse(P_ETK);
        chk_val(status, 24'h000000);
        for (int r = 0; r < 4; r++) begin
            reg_wr(BIM_ADDR_MGMT, {22'h1ec001, r[1:0]});
            cnt = 0;
            repeat (16) begin
                pulse(P_SAMPLE_SYNC_PULSE);
                cnt += int'(status[9] === 1'b1);
                pulse(P_QTK);
                chk_val(status, 24'h000000);
            end
            chk_val(cnt, 24'd16 >> (r == 3 ? 4 : r));
        end
        // Secondary line carries only the sample pulse here
        reg_wr(BIM_ADDR_MASK_SEC, 24'h000201);
        reg_wr(BIM_ADDR_MGMT, 24'h7b0000);
        pulse(P_SAMPLE_SYNC_PULSE);
        pulse(P_QTK);
        chk_val(status, 24'h000200);
        chk_pin({2'h0, line_s}, 3'h0);
        pulse(P_SRD);
        chk_val(status, 24'h000000);
        final_report();
    end
endmodule : tb_bim_irq_manager
